// file: verilog/apms_sequencer.sv
// Purpose: Power-mode sequencer and serial read-out of a dual converter.
// Assumes: Results are stable link-domain inputs during a frame.
// Notes:   Frame logic runs on the link clock and is cleared by select high.
//
// Behaviour
// - Select falling samples, starts conversion and drives both outputs.
// - A link falling edge coincident with select falling is not counted.
// - Select rising between edges ten and fourteen aborts, stays powered.
// - After fourteen cycles the output stays driven until select rises or edge thirty-two.
// - Two more cycles low shift out two trailing zero bits.
// - A further fourteen or sixteen cycles deliver the other result.
// - Active output floats on edge thirty-two or earlier select rise.
// - From normal, rise between edges two and ten enters partial down.
// - From normal, rise before edge two keeps normal mode.
// - Dummy conversion past edge ten wakes partial down in about 1 us.
// - In partial down, rise before edge two powers down again.
// - In partial down, rise between edges two and ten enters full down.
// - Power-on mode is any of three; one dummy cycle recommended.

`timescale 1ns/1ps
`default_nettype none

module apms_sequencer #(
  parameter int                  FULL_WAKE = apms_pkg::FULL_WAKE_CYCLES,
  parameter apms_pkg::apms_mode_t RESET_MODE = apms_pkg::MODE_NORMAL
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        conversion_serial_clock,
  input  wire logic        conv_select_n,
  input  wire logic [11:0] result_a,
  input  wire logic [11:0] result_b,
  output logic             serial_result_out_a,
  output logic             serial_result_out_a_oe,
  output logic             serial_result_out_b,
  output logic             serial_result_out_b_oe,
  output logic             track_hold,
  output logic [1:0]       mode_state,
  output logic             analog_power_en,
  output logic             converter_ready,
  output logic             conversion_aborted
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  localparam int CW = apms_pkg::COUNT_W;
  localparam int TW = apms_pkg::TIMER_W;

  logic                 link_arst_n;
  logic [CW-1:0]        edge_count;
  logic [CW-1:0]        next_edge_count;
  logic                 reach_glitch;
  logic                 reach_powered;
  logic                 reach_result;
  logic                 frame_done;
  logic                 track_back;
  logic                 bit_a;
  logic                 bit_b;
  logic [3:0]           sync_in;
  logic [3:0]           sync_out;
  logic                 s_cs_n;
  logic                 s_glitch;
  logic                 s_powered;
  logic                 s_result;
  logic                 cs_prev;
  logic                 cs_fall;
  logic                 cs_rise;
  logic                 seen_glitch;
  logic                 seen_powered;
  logic                 seen_result;
  apms_pkg::apms_mode_t mode;
  apms_pkg::apms_mode_t next_mode;
  logic                 next_power_en;
  logic                 wake_start;
  logic [TW-1:0]        wake_load;
  logic                 wake_busy;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  // Bit that a data line carries once the given falling edge has passed.
  function automatic logic apms_frame_bit(
    input logic [CW-1:0] pos,
    input logic [11:0]   first,
    input logic [11:0]   second
  );
    int   p;
    logic b;
    p = int'(pos);
    b = 1'h0;
    if (p >= apms_pkg::FIRST_MSB_EDGE && p <= apms_pkg::FIRST_LSB_EDGE) begin
      b = first[apms_pkg::FIRST_LSB_EDGE - p];
    end else if (p >= apms_pkg::SECOND_MSB_EDGE &&
                 p <= apms_pkg::SECOND_LSB_EDGE) begin
      b = second[apms_pkg::SECOND_LSB_EDGE - p];
    end
    return b;
  endfunction

  // Mode reached on select rising, from the edges seen and the mode held.
  function automatic apms_pkg::apms_mode_t apms_decide(
    input apms_pkg::apms_mode_t cur,
    input logic                 past_glitch,
    input logic                 past_powered
  );
    apms_pkg::apms_mode_t m;
    m = cur;
    if (past_powered) begin
      m = apms_pkg::MODE_NORMAL;
    end else if (past_glitch) begin
      unique case (cur)
        apms_pkg::MODE_NORMAL:       m = apms_pkg::MODE_PARTIAL_DOWN;
        apms_pkg::MODE_PARTIAL_DOWN: m = apms_pkg::MODE_FULL_DOWN;
        apms_pkg::MODE_FULL_DOWN:    m = apms_pkg::MODE_FULL_DOWN;
        default:                     m = apms_pkg::MODE_FULL_DOWN;
      endcase
    end else begin
      m = cur;
    end
    return m;
  endfunction

  // --------------------------------------------------------------------
  // Link domain: edge counting
  // --------------------------------------------------------------------
  // Select high holds the frame logic cleared, so nothing in this domain
  // relies on a link edge after the frame has ended.
  assign link_arst_n = rstn & ~conv_select_n;

  always_comb begin
    next_edge_count = edge_count;
    if (edge_count < CW'(apms_pkg::FRAME_EDGES)) begin
      next_edge_count = edge_count + CW'(1);
    end
  end

  // An edge arriving as the clear releases is lost to recovery on purpose.
  always_ff @(negedge conversion_serial_clock or negedge link_arst_n) begin
    if (!link_arst_n) begin
      edge_count <= '0;
    end else begin
      edge_count <= next_edge_count;
    end
  end

  always_ff @(negedge conversion_serial_clock or negedge link_arst_n) begin
    if (!link_arst_n) begin
      reach_glitch  <= 1'h0;
      reach_powered <= 1'h0;
      reach_result  <= 1'h0;
    end else begin
      reach_glitch  <= (next_edge_count >= CW'(apms_pkg::GLITCH_EDGES));
      reach_powered <= (next_edge_count >= CW'(apms_pkg::POWERED_EDGES));
      reach_result  <= (next_edge_count >= CW'(apms_pkg::RESULT_EDGES));
    end
  end

  // --------------------------------------------------------------------
  // Link domain: serial data and drive enables
  // --------------------------------------------------------------------
  // Cleared to zero while select is high: the first bit after select
  // falls is the leading zero.
  always_ff @(negedge conversion_serial_clock or negedge link_arst_n) begin
    if (!link_arst_n) begin
      bit_a <= 1'h0;
      bit_b <= 1'h0;
    end else begin
      bit_a <= apms_frame_bit(next_edge_count, result_a, result_b);
      bit_b <= apms_frame_bit(next_edge_count, result_b, result_a);
    end
  end

  // Trailing zeros fall out of the frame bit map between the two words.
  assign serial_result_out_a = bit_a;
  assign serial_result_out_b = bit_b;

  always_ff @(negedge conversion_serial_clock or negedge link_arst_n) begin
    if (!link_arst_n) begin
      frame_done <= 1'h0;
    end else if (next_edge_count == CW'(apms_pkg::FRAME_EDGES)) begin
      frame_done <= 1'h1;
    end
  end

  // Drive follows select directly, so a rise floats the lines at once and
  // the thirty-second edge releases them if select is still low.
  assign serial_result_out_a_oe = ~conv_select_n & ~frame_done;
  assign serial_result_out_b_oe = ~conv_select_n & ~frame_done;

  // --------------------------------------------------------------------
  // Link domain: track and hold
  // --------------------------------------------------------------------
  always_ff @(posedge conversion_serial_clock or negedge link_arst_n) begin
    if (!link_arst_n) begin
      track_back <= 1'h0;
    end else if (edge_count >= CW'(apms_pkg::TRACK_EDGES)) begin
      track_back <= 1'h1;
    end
  end

  assign track_hold = ~conv_select_n & ~track_back;

  // --------------------------------------------------------------------
  // Crossing into the main clock
  // --------------------------------------------------------------------
  // Each flag only rises within a frame, so bits may cross one by one.
  assign sync_in = {conv_select_n, reach_result, reach_powered, reach_glitch};

  apms_sync #(
    .W    (4),
    .INIT (4'h8)
  ) u_sync (
    .clk  (mclk),
    .rstn (rstn),
    .din  (sync_in),
    .dout (sync_out)
  );

  assign s_glitch  = sync_out[0];
  assign s_powered = sync_out[1];
  assign s_result  = sync_out[2];
  assign s_cs_n    = sync_out[3];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_prev <= 1'h1;
    end else begin
      cs_prev <= s_cs_n;
    end
  end

  assign cs_fall = cs_prev & ~s_cs_n;
  assign cs_rise = ~cs_prev & s_cs_n;

  // --------------------------------------------------------------------
  // Edge milestones seen during the frame
  // --------------------------------------------------------------------
  // The flags clear with select high; keeping them here means the clear
  // racing the rise of select cannot hide the count that was reached.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seen_glitch  <= 1'h0;
      seen_powered <= 1'h0;
      seen_result  <= 1'h0;
    end else begin
      seen_glitch  <= s_glitch  | (seen_glitch  & ~cs_fall);
      seen_powered <= s_powered | (seen_powered & ~cs_fall);
      seen_result  <= s_result  | (seen_result  & ~cs_fall);
    end
  end

  // --------------------------------------------------------------------
  // Mode state
  // --------------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    if (cs_rise) begin
      next_mode = apms_decide(mode, seen_glitch | s_glitch,
                              seen_powered | s_powered);
    end
  end

  // Power-on mode is a parameter; software must not trust the default.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode <= RESET_MODE;
    end else begin
      mode <= next_mode;
    end
  end

  assign mode_state = mode;

  // Pulse that tells the core a conversion was cut short.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      conversion_aborted <= 1'h0;
    end else begin
      conversion_aborted <= cs_rise & ~(seen_result | s_result);
    end
  end

  // --------------------------------------------------------------------
  // Analog power and wake-up
  // --------------------------------------------------------------------
  // A dummy conversion powers the core while select is low; a rise too
  // early drops power again.
  assign next_power_en = (next_mode == apms_pkg::MODE_NORMAL) | ~s_cs_n;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      analog_power_en <= (RESET_MODE == apms_pkg::MODE_NORMAL);
    end else begin
      analog_power_en <= next_power_en;
    end
  end

  assign wake_start = cs_fall & (mode != apms_pkg::MODE_NORMAL);
  assign wake_load  = (mode == apms_pkg::MODE_FULL_DOWN) ?
                      TW'(FULL_WAKE) :
                      TW'(apms_pkg::PARTIAL_WAKE_CYCLES);

  apms_wake_timer #(
    .W (TW)
  ) u_wake (
    .clk   (mclk),
    .rstn  (rstn),
    .start (wake_start),
    .load  (wake_load),
    .abort (~next_power_en),
    .busy  (wake_busy)
  );

  // Ready only once powered and the wake time has run out.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      converter_ready <= 1'h0;
    end else begin
      converter_ready <= analog_power_en & ~wake_busy &
                         (mode == apms_pkg::MODE_NORMAL);
    end
  end

endmodule // apms_sequencer

`default_nettype wire

// file: pkg/apms_pkg.sv
// Purpose: Shared constants and types of the converter power-mode sequencer.
// Assumes: Main clock of 25 MHz; frame positions count link falling edges.
// Notes:   Times are kept as printed, cycle counts derive from them.

package apms_pkg;

  // --------------------------------------------------------------------
  // Clock and wake-up timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 40;
  localparam int PARTIAL_WAKE_NS     = 1000;
  localparam int FULL_WAKE_NS        = 1500000;
  localparam int PARTIAL_WAKE_CYCLES =
    (PARTIAL_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_WAKE_CYCLES    =
    (FULL_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W             = 16;

  // --------------------------------------------------------------------
  // Frame positions, in counted falling edges of the link clock
  // --------------------------------------------------------------------
  localparam int COUNT_W         = 6;
  localparam int RESULT_BITS     = 12;
  localparam int LEAD_ZEROS      = 2;
  localparam int GLITCH_EDGES    = 2;
  localparam int POWERED_EDGES   = 10;
  localparam int TRACK_EDGES     = 13;
  localparam int RESULT_EDGES    = 14;
  localparam int TRAIL_EDGES     = 2;
  localparam int FRAME_EDGES     = 32;
  localparam int FIRST_MSB_EDGE  = LEAD_ZEROS;
  localparam int FIRST_LSB_EDGE  = LEAD_ZEROS + RESULT_BITS - 1;
  localparam int SECOND_MSB_EDGE = RESULT_EDGES + TRAIL_EDGES + LEAD_ZEROS;
  localparam int SECOND_LSB_EDGE = SECOND_MSB_EDGE + RESULT_BITS - 1;

  // --------------------------------------------------------------------
  // Operating modes
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PARTIAL_DOWN,
    MODE_FULL_DOWN
  } apms_mode_t;

endpackage

// file: verilog/apms_sync.sv
// Purpose: Two-stage synchroniser for single-bit levels.
// Assumes: Each bit is a monotonic level; bits are not read as one word.
// Notes:   Only the second stage leaves this module.

`timescale 1ns/1ps
`default_nettype none

module apms_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // apms_sync

`default_nettype wire

// file: verilog/apms_wake_timer.sv
// Purpose: Down-counter that holds busy while the analog core wakes up.
// Assumes: Start and abort are single-cycle or level terms of the clock.
// Notes:   Abort wins over start, since power is being removed.

`timescale 1ns/1ps
`default_nettype none

module apms_wake_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  input  wire logic         abort,
  output logic              busy
);

  logic [W-1:0] remaining;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remaining <= '0;
    end else if (abort) begin
      remaining <= '0;
    end else if (start) begin
      remaining <= load;
    end else if (remaining != '0) begin
      remaining <= remaining - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'h0;
    end else if (abort) begin
      busy <= 1'h0;
    end else if (start) begin
      busy <= (load != '0);
    end else if (remaining <= W'(1)) begin
      busy <= 1'h0;
    end
  end

endmodule // apms_wake_timer

`default_nettype wire

// file: verification/apms_checker.sv
// Purpose: Port-level checks of the power-mode sequencer.
// Assumes: Link falling edges come at least 48 ns apart.
// Notes:   Mode checks read the edge count held just before select rose.

`timescale 1ns/1ps
`default_nettype none

module apms_checker (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        conversion_serial_clock,
  input wire logic        conv_select_n,
  input wire logic [11:0] result_a,
  input wire logic [11:0] result_b,
  input wire logic        serial_result_out_a,
  input wire logic        serial_result_out_a_oe,
  input wire logic        serial_result_out_b,
  input wire logic        serial_result_out_b_oe,
  input wire logic        track_hold,
  input wire logic [1:0]  mode_state,
  input wire logic        analog_power_en,
  input wire logic        converter_ready,
  input wire logic        conversion_aborted
);
  // --------------------------------------------------------------------
  // Edge count
  // --------------------------------------------------------------------
  logic       sel_dly;
  logic [5:0] edges;
  logic [5:0] held;

  // The delayed select drops a link fall that coincides with select fall.
  assign #1 sel_dly = conv_select_n;

  always_ff @(negedge conversion_serial_clock or posedge conv_select_n) begin
    if (conv_select_n) edges <= 6'h00;
    else if (!sel_dly && edges < 6'h20) edges <= edges + 6'h01;
  end

  always_ff @(posedge mclk) begin
    if (!conv_select_n) held <= edges;
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence sel_rise;
    $rose(conv_select_n);
  endsequence

  oe_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
    !conv_select_n && edges < 6'h20 |->
      serial_result_out_a_oe && serial_result_out_b_oe)
    else $error("output enable low inside frame");
  oe_release_a: assert property (@(posedge mclk) disable iff (!rstn)
    conv_select_n || edges == 6'h20 |->
      !serial_result_out_a_oe && !serial_result_out_b_oe)
    else $error("output enable high outside frame");
  zero_bits_a: assert property (@(posedge conversion_serial_clock)
    disable iff (!rstn || conv_select_n)
    edges inside {0, 1, [14:17], 30, 31} |->
      !serial_result_out_a && !serial_result_out_b)
    else $error("padding bit not zero");
  own_word_a: assert property (@(posedge conversion_serial_clock)
    disable iff (!rstn || conv_select_n)
    edges inside {[2:13]} |-> serial_result_out_a == result_a[13-edges]
      && serial_result_out_b == result_b[13-edges])
    else $error("own result bit wrong");
  other_word_a: assert property (@(posedge conversion_serial_clock)
    disable iff (!rstn || conv_select_n)
    edges inside {[18:29]} |-> serial_result_out_a == result_b[29-edges]
      && serial_result_out_b == result_a[29-edges])
    else $error("other result bit wrong");
  glitch_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
    sel_rise ##0 (mode_state == 2'h0 && held < 6'h02) |=>
      (mode_state == 2'h0) [*6])
    else $error("short frame left normal mode");
  enter_part_a: assert property (@(posedge mclk) disable iff (!rstn)
    sel_rise ##0 (mode_state == 2'h0 && held inside {[2:9]}) |->
      ##[1:6] (mode_state == 2'h1 && !analog_power_en))
    else $error("partial power-down not entered");
  part_stay_a: assert property (@(posedge mclk) disable iff (!rstn)
    sel_rise ##0 (mode_state == 2'h1 && held < 6'h02) |->
      ##6 (mode_state == 2'h1 && !analog_power_en))
    else $error("partial power-down not kept");
  enter_full_a: assert property (@(posedge mclk) disable iff (!rstn)
    sel_rise ##0 (mode_state == 2'h1 && held inside {[2:9]}) |->
      ##[1:6] mode_state == 2'h2)
    else $error("full power-down not entered");
  wake_normal_a: assert property (@(posedge mclk) disable iff (!rstn)
    sel_rise ##0 held >= 6'h0A |-> ##[1:6] mode_state == 2'h0)
    else $error("long frame did not give normal mode");
  abort_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
    sel_rise ##0 held < 6'h0E |-> ##[1:6] conversion_aborted)
    else $error("abort not flagged");
  ready_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(converter_ready) |-> mode_state == 2'h0 && analog_power_en)
    else $error("ready outside normal mode");
  track_hold_a: assert property (@(posedge conversion_serial_clock)
    disable iff (!rstn || conv_select_n)
    edges < 6'h0E |-> track_hold)
    else $error("hold released early");
  track_back_a: assert property (@(posedge conversion_serial_clock)
    disable iff (!rstn || conv_select_n)
    edges >= 6'h0E |-> !track_hold)
    else $error("hold kept after conversion");
  no_abort_a: assert property (@(posedge mclk) disable iff (!rstn)
    sel_rise ##0 held >= 6'h0E |=> (!conversion_aborted) [*6])
    else $error("complete frame flagged as abort");
endmodule // apms_checker

`default_nettype wire

// file: verification/apms_host.sv
// Purpose: Host serial port that frames conversions and reads both lines.
// Assumes: Link clock idles high and stands still between frames.
// Notes:   Bits are taken just before each falling edge, first bit first.

`timescale 1ns/1ps
`default_nettype none

module apms_host (
  output logic      sclk,
  output logic      sel_n,
  input  wire logic da,
  input  wire logic da_oe,
  input  wire logic db,
  input  wire logic db_oe
);
  logic [31:0] cap_a;
  logic [31:0] cap_b;
  logic        oe_end;

  initial begin
    sclk   = 1'b1;
    sel_n  <= 1'b1;
    cap_a  = 32'h0000_0000;
    cap_b  = 32'h0000_0000;
    oe_end = 1'b0;
  end

  // A frame of n counted falls; coinc adds a fall on the select edge.
  task automatic frame(input int n, input bit coinc);
    cap_a = 32'h0000_0000;
    cap_b = 32'h0000_0000;
    // Select falls after the link edge of the same step, so a coincident
    // edge still meets the frame logic cleared.
    sel_n <= 1'b0;
    sclk  = !coinc;
    #24 sclk = 1'b1;
    #76;
    repeat (n) begin
      cap_a = {cap_a[30:0], da};
      cap_b = {cap_b[30:0], db};
      sclk  = 1'b0;
      #24 sclk = 1'b1;
      #24;
    end
    oe_end = da_oe | db_oe;
    sel_n  <= 1'b1;
    #400;
  endtask
endmodule // apms_host

`default_nettype wire

// file: verification/apms_sequencer_bench.sv
// Purpose: Self-checking bench of the power-mode sequencer.
// Assumes: Results stay fixed while a frame runs.
// Notes:   Full wake is shortened to 50 cycles to keep the run short.

`timescale 1ns/1ps
`default_nettype none

module apms_sequencer_bench;
  localparam int FW = 50;
  logic        mclk;
  logic        rstn;
  logic        sclk;
  logic        sel_n;
  logic [11:0] ra;
  logic [11:0] rb;
  logic        da;
  logic        da_oe;
  logic        db;
  logic        db_oe;
  logic        th;
  logic [1:0]  mode;
  logic        pwr;
  logic        rdy;
  logic        abt;
  int          n_mismatch;
  int          cmp_count;

  always #20 mclk = ~mclk;

  apms_sequencer #(.FULL_WAKE(FW)) u_apms_sequencer (
    .mclk(mclk), .rstn(rstn), .conversion_serial_clock(sclk),
    .conv_select_n(sel_n), .result_a(ra), .result_b(rb),
    .serial_result_out_a(da), .serial_result_out_a_oe(da_oe),
    .serial_result_out_b(db), .serial_result_out_b_oe(db_oe),
    .track_hold(th), .mode_state(mode), .analog_power_en(pwr),
    .converter_ready(rdy), .conversion_aborted(abt));

  apms_host u_apms_host (.sclk(sclk), .sel_n(sel_n), .da(da),
    .da_oe(da_oe), .db(db), .db_oe(db_oe));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // A missing ready would hang later frames, so the run stops here.
  task automatic wait_ready(input int lim);
    int i;
    i = 0;
    while (rdy !== 1'b1 && i < lim) begin
      @(posedge mclk);
      #2;
      i++;
    end
    check("ready", rdy, 32'h1);
    if (rdy !== 1'b1) report_and_stop();
  endtask

  task automatic set_results(input logic [11:0] a, input logic [11:0] b);
    @(posedge mclk);
    #2 ra = a;
    rb = b;
  endtask

  task automatic t_reset;
    check("mode", mode, 32'h0);
    wait_ready(5);
  endtask

  task automatic t_read_both;
    set_results(12'hA5C, 12'h3B1);
    u_apms_host.frame(32, 1'b0);
    check("a", u_apms_host.cap_a, {2'h0, ra, 4'h0, rb, 2'h0});
    check("b", u_apms_host.cap_b, {2'h0, rb, 4'h0, ra, 2'h0});
    check("oe", u_apms_host.oe_end, 32'h0);
  endtask

  task automatic t_read_16;
    set_results(12'h5A3, 12'hC4E);
    u_apms_host.frame(16, 1'b0);
    check("a", u_apms_host.cap_a, {16'h0000, 2'h0, ra, 2'h0});
    check("b", u_apms_host.cap_b, {16'h0000, 2'h0, rb, 2'h0});
    check("oe", u_apms_host.oe_end, 32'h1);
  endtask

  task automatic t_abort_ten;
    u_apms_host.frame(10, 1'b0);
    check("mode", mode, 32'h0);
    u_apms_host.frame(13, 1'b0);
    check("mode", mode, 32'h0);
    u_apms_host.frame(1, 1'b0);
    check("mode", mode, 32'h0);
  endtask

  task automatic t_partial;
    u_apms_host.frame(9, 1'b1);
    check("mode", mode, 32'h1);
    u_apms_host.frame(1, 1'b0);
    check("mode", mode, 32'h1);
    check("power", pwr, 32'h0);
  endtask

  task automatic t_full;
    u_apms_host.frame(2, 1'b0);
    check("mode", mode, 32'h2);
    u_apms_host.frame(1, 1'b0);
    check("mode", mode, 32'h2);
  endtask

  task automatic t_wake_full;
    u_apms_host.frame(10, 1'b0);
    check("mode", mode, 32'h0);
    check("early", rdy, 32'h0);
    wait_ready(FW + 20);
  endtask

  task automatic t_wake_partial;
    u_apms_host.frame(5, 1'b0);
    check("mode", mode, 32'h1);
    #67000;
    u_apms_host.frame(10, 1'b0);
    check("mode", mode, 32'h0);
    wait_ready(40);
  endtask

  // A second reset mid-run, then the dummy cycles that reach each mode.
  task automatic t_power_on;
    rstn = 1'b0;
    repeat (2) @(posedge mclk);
    #2 rstn = 1'b1;
    repeat (3) @(posedge mclk);
    #2;
    check("mode", mode, 32'h0);
    u_apms_host.frame(10, 1'b0);
    check("mode", mode, 32'h0);
    u_apms_host.frame(5, 1'b0);
    check("mode", mode, 32'h1);
    check("power", pwr, 32'h0);
    u_apms_host.frame(5, 1'b0);
    check("mode", mode, 32'h2);
  endtask

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    ra = 12'h000;
    rb = 12'h000;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (12) @(posedge mclk);
    #2 rstn = 1'b1;
    repeat (3) @(posedge mclk);
    #2;
    t_reset();
    t_read_both();
    t_read_16();
    t_abort_ten();
    t_partial();
    t_full();
    t_wake_full();
    t_wake_partial();
    t_power_on();
    report_and_stop();
  end
endmodule // apms_sequencer_bench

bind apms_sequencer apms_checker u_apms_checker (
  .mclk(mclk), .rstn(rstn), .conversion_serial_clock(conversion_serial_clock),
  .conv_select_n(conv_select_n), .result_a(result_a), .result_b(result_b),
  .serial_result_out_a(serial_result_out_a),
  .serial_result_out_a_oe(serial_result_out_a_oe),
  .serial_result_out_b(serial_result_out_b),
  .serial_result_out_b_oe(serial_result_out_b_oe),
  .track_hold(track_hold), .mode_state(mode_state),
  .analog_power_en(analog_power_en), .converter_ready(converter_ready),
  .conversion_aborted(conversion_aborted));

`default_nettype wire
